/* File: hdl/mlb_bus_unit.sv */
// Multiplexed local bus cycle engine of an 8-bit processor
// Overview of operation
// - Low byte carries address in T1, data in T2, T3, Tw and T4.
// - Low byte floats during interrupt acknowledge and hold acknowledge.
// - Middle address byte holds address bits 8 to 15 throughout T1 to T4.
// - Memory cycle T1 drives address bits 19 to 16 on upper lines.
// - I/O cycle T1 drives all four upper lines low.
// - Upper lines carry status during T2, T3, Tw and T4.
// - Top status bit is always low.
// - Second status bit shows interrupt enable flag, refreshed every clock.
// - Two lowest status bits encode segment in use.
// - Read strobe low during T2, T3 and Tw of read cycles.
// - Interrupt request sampled in last clock of each instruction.
// - Wait-for-poll continues when poll low, else idles until low.
// - Poll input synchronised every rising clock edge before use.
// - Latch strobe pulses high in T1 of every cycle, never floats.
// - Write strobe low during T2, T3 and Tw of write cycles.
// - Space select high for I/O, low for memory.
`timescale 1ns/1ps
`default_nettype none
module mlb_bus_unit
(
  input  wire logic        I_CLK,
  input  wire logic        I_RESETN,
  input  wire logic        I_REQ,
  input  wire logic        I_REQ_WRITE,
  input  wire logic        I_REQ_IO,
  input  wire logic        I_REQ_INTA,
  input  wire logic [19:0] I_REQ_ADDR,
  input  wire logic [7:0]  I_REQ_WDATA,
  input  wire logic [1:0]  I_SEGMENT,
  input  wire logic        I_IRQ_ENABLE_FLAG,
  input  wire logic        I_INSTR_LAST_CLK,
  input  wire logic        I_WAIT_POLL_EXEC,
  input  wire logic        I_HOLD_ACK,
  input  wire logic        I_READY,
  input  wire logic        I_MASKABLE_IRQ_REQUEST,
  input  wire logic        I_POLL_N,
  input  wire logic [7:0]  I_MUXED_ADDR_DATA_LOW,
  output logic [7:0]  O_MUXED_ADDR_DATA_LOW,
  output logic        O_MUXED_ADDR_DATA_LOW_OE,
  output logic [7:0]  O_MID_ADDRESS_BYTE,
  output logic        O_MID_ADDRESS_BYTE_OE,
  output logic [3:0]  O_UPPER_ADDR_STATUS,
  output logic        O_UPPER_ADDR_STATUS_OE,
  output logic        O_ADDR_LATCH,
  output logic        O_READ_N,
  output logic        O_WRITE_N,
  output logic        O_IO_SELECT,
  output logic        O_CTRL_OE,
  output logic        O_BUSY,
  output logic        O_DONE,
  output logic [7:0]  O_RDATA,
  output logic        O_IRQ_TAKE,
  output logic        O_POLL_STALL
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] ready_sync_r;
  logic [1:0] irq_sync_r;
  logic [1:0] poll_sync_r;
  logic [7:0] din_s1_r;
  logic [7:0] din_s2_r;

  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      ready_sync_r <= 2'h0;
      irq_sync_r   <= 2'h0;
      poll_sync_r  <= 2'h3;
      din_s1_r     <= mlb_pkg::RST_BYTE;
      din_s2_r     <= mlb_pkg::RST_BYTE;
    end
    else
    begin
      ready_sync_r <= {ready_sync_r[0], I_READY};
      irq_sync_r   <= {irq_sync_r[0], I_MASKABLE_IRQ_REQUEST};
      poll_sync_r  <= {poll_sync_r[0], I_POLL_N};
      din_s1_r     <= I_MUXED_ADDR_DATA_LOW;
      din_s2_r     <= din_s1_r;
    end
  end

  // ----------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------
  mlb_pkg::mlb_state_t state_r;
  logic        wr_r;
  logic        io_r;
  logic        inta_r;
  logic [19:0] addr_r;
  logic [7:0]  wdata_r;

  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      state_r <= mlb_pkg::ST_IDLE;
    else
      case (state_r)
        mlb_pkg::ST_IDLE: if (I_REQ && !I_HOLD_ACK) state_r <= mlb_pkg::ST_T1;
        mlb_pkg::ST_T1:   state_r <= mlb_pkg::ST_T2;
        mlb_pkg::ST_T2:   state_r <= mlb_pkg::ST_T3;
        mlb_pkg::ST_T3,
        mlb_pkg::ST_TW:   state_r <= ready_sync_r[1] ? mlb_pkg::ST_T4 : mlb_pkg::ST_TW;
        mlb_pkg::ST_T4:   state_r <= mlb_pkg::ST_IDLE;
        default:          state_r <= mlb_pkg::ST_IDLE;
      endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      wr_r    <= 1'h0;
      io_r    <= 1'h0;
      inta_r  <= 1'h0;
      addr_r  <= 20'h00000;
      wdata_r <= mlb_pkg::RST_BYTE;
    end
    else if (state_r == mlb_pkg::ST_IDLE && I_REQ && !I_HOLD_ACK)
    begin
      wr_r    <= I_REQ_WRITE & ~I_REQ_INTA;
      io_r    <= I_REQ_IO;
      inta_r  <= I_REQ_INTA;
      addr_r  <= I_REQ_ADDR;
      wdata_r <= I_REQ_WDATA;
    end
  end

  // ----------------------------------------
  // Next pin values, registered
  // ----------------------------------------
  logic       in_cycle;
  logic       strobe_ph;
  mlb_pkg::mlb_state_t state_nxt;
  logic [7:0] ad_nxt;
  logic       ad_oe_nxt;
  logic [3:0] up_nxt;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      mlb_pkg::ST_IDLE: if (I_REQ && !I_HOLD_ACK) state_nxt = mlb_pkg::ST_T1;
      mlb_pkg::ST_T1:   state_nxt = mlb_pkg::ST_T2;
      mlb_pkg::ST_T2:   state_nxt = mlb_pkg::ST_T3;
      mlb_pkg::ST_T3,
      mlb_pkg::ST_TW:   state_nxt = ready_sync_r[1] ? mlb_pkg::ST_T4 : mlb_pkg::ST_TW;
      mlb_pkg::ST_T4:   state_nxt = mlb_pkg::ST_IDLE;
      default:          state_nxt = mlb_pkg::ST_IDLE;
    endcase
    in_cycle  = (state_nxt != mlb_pkg::ST_IDLE);
    strobe_ph = (state_nxt == mlb_pkg::ST_T2) || (state_nxt == mlb_pkg::ST_T3) || (state_nxt == mlb_pkg::ST_TW);
    ad_nxt    = (state_nxt == mlb_pkg::ST_T1) ? I_REQ_ADDR[7:0] : wdata_r;
    ad_oe_nxt = in_cycle && !I_HOLD_ACK
                && ((state_nxt == mlb_pkg::ST_T1) ? !I_REQ_INTA : (!inta_r && wr_r));
    if (state_nxt == mlb_pkg::ST_T1)
      up_nxt = I_REQ_IO ? mlb_pkg::IO_UPPER_ADDR : I_REQ_ADDR[19:16];
    else
      up_nxt = {mlb_pkg::STATUS_MSB_VAL, I_IRQ_ENABLE_FLAG, I_SEGMENT};
  end

  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_MUXED_ADDR_DATA_LOW    <= mlb_pkg::RST_BYTE;
      O_MUXED_ADDR_DATA_LOW_OE <= 1'h0;
      O_MID_ADDRESS_BYTE       <= mlb_pkg::RST_BYTE;
      O_MID_ADDRESS_BYTE_OE    <= 1'h0;
      O_UPPER_ADDR_STATUS      <= mlb_pkg::RST_NIBBLE;
      O_UPPER_ADDR_STATUS_OE   <= 1'h0;
      O_ADDR_LATCH             <= 1'h0;
      O_READ_N                 <= 1'h1;
      O_WRITE_N                <= 1'h1;
      O_IO_SELECT              <= 1'h0;
      O_CTRL_OE                <= 1'h0;
    end
    else
    begin
      O_MUXED_ADDR_DATA_LOW    <= ad_nxt;
      O_MUXED_ADDR_DATA_LOW_OE <= ad_oe_nxt;
      if (state_nxt == mlb_pkg::ST_T1)
        O_MID_ADDRESS_BYTE <= I_REQ_ADDR[15:8];
      O_MID_ADDRESS_BYTE_OE    <= !I_HOLD_ACK;
      O_UPPER_ADDR_STATUS      <= up_nxt;
      O_UPPER_ADDR_STATUS_OE   <= !I_HOLD_ACK;
      O_ADDR_LATCH             <= (state_nxt == mlb_pkg::ST_T1);
      O_READ_N                 <= !(strobe_ph && !wr_r && !inta_r);
      O_WRITE_N                <= !(strobe_ph && wr_r);
      if (state_nxt == mlb_pkg::ST_T1)
        O_IO_SELECT <= I_REQ_IO;
      O_CTRL_OE                <= !I_HOLD_ACK;
    end
  end

  // ----------------------------------------
  // Completion, interrupt sampling and poll wait
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_BUSY       <= 1'h0;
      O_DONE       <= 1'h0;
      O_RDATA      <= mlb_pkg::RST_BYTE;
      O_IRQ_TAKE   <= 1'h0;
      O_POLL_STALL <= 1'h0;
    end
    else
    begin
      O_BUSY       <= in_cycle;
      O_DONE       <= (state_r == mlb_pkg::ST_T4);
      if (state_r == mlb_pkg::ST_T4 && !wr_r)
        O_RDATA <= din_s2_r;
      O_IRQ_TAKE   <= I_INSTR_LAST_CLK && irq_sync_r[1];
      O_POLL_STALL <= I_WAIT_POLL_EXEC && poll_sync_r[1];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_LATCH_T1: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    O_ADDR_LATCH |-> $past(state_nxt) == mlb_pkg::ST_T1 && state_r == mlb_pkg::ST_T1)
    else $error("latch strobe outside T1");
  AST_CYCLE_ORDER: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    state_r == mlb_pkg::ST_T1 |=> state_r == mlb_pkg::ST_T2 ##1 state_r == mlb_pkg::ST_T3)
    else $error("cycle order broken");
  AST_WAIT_READY: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_r == mlb_pkg::ST_T3 && !ready_sync_r[1]) |=> state_r == mlb_pkg::ST_TW)
    else $error("wait state missing");
  AST_STATUS_MSB: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_r == mlb_pkg::ST_T3) |-> !O_UPPER_ADDR_STATUS[3])
    else $error("status msb not low");
  AST_IO_T1_LOW: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_r == mlb_pkg::ST_T1 && io_r) |-> O_UPPER_ADDR_STATUS == mlb_pkg::IO_UPPER_ADDR)
    else $error("io upper lines not low");
  AST_READ_STROBE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_r == mlb_pkg::ST_T2 && !wr_r && !inta_r) |-> !O_READ_N && O_WRITE_N)
    else $error("read strobe wrong");
  AST_WRITE_STROBE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_r == mlb_pkg::ST_T4) |-> O_WRITE_N && O_READ_N)
    else $error("strobe held in T4");
  AST_MID_STABLE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_r == mlb_pkg::ST_T2) |-> O_MID_ADDRESS_BYTE == addr_r[15:8] && $stable(O_MID_ADDRESS_BYTE))
    else $error("middle byte not stable");
  AST_HOLD_FLOAT: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    $past(I_HOLD_ACK) |-> !O_MID_ADDRESS_BYTE_OE && !O_UPPER_ADDR_STATUS_OE && !O_MUXED_ADDR_DATA_LOW_OE)
    else $error("bus not released in hold");
  AST_POLL: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_WAIT_POLL_EXEC && poll_sync_r[1]) |=> O_POLL_STALL)
    else $error("poll stall missing");

endmodule
`default_nettype wire

/* File: shared/mlb_pkg.sv */
// Package: constants and types for the multiplexed local bus interface
package mlb_pkg;
  localparam logic [3:0] IO_UPPER_ADDR  = 4'h0;
  localparam logic [1:0] SEG_ALT_DATA   = 2'h0;
  localparam logic [1:0] SEG_STACK      = 2'h1;
  localparam logic [1:0] SEG_CODE       = 2'h2;
  localparam logic [1:0] SEG_DATA       = 2'h3;
  localparam logic       STATUS_MSB_VAL = 1'h0;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [3:0] RST_NIBBLE     = 4'h0;
  typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4} mlb_state_t;
endpackage

/* File: sim/mlb_dev_model.sv */
// Device model: memory or I/O part answering local bus cycles
`timescale 1ns/1ps
`default_nettype none
module mlb_dev_model
(
  input  wire logic       i_clk,
  input  wire logic       i_latch,
  input  wire logic       i_read_n,
  input  wire logic [7:0] i_addr,
  input  wire logic [3:0] i_waits,
  output logic            o_ready,
  output logic [7:0]      o_pin
);
  logic [7:0] addr_r = 8'h00;
  logic [3:0] cnt_r = 4'h0;
  initial o_pin = 8'h00;
  assign o_ready = (cnt_r == 4'h0);
  always @(negedge i_clk)
  begin
    if (i_latch)
    begin
      addr_r <= i_addr;
      cnt_r  <= i_waits;
    end
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
    o_pin <= i_read_n ? ~o_pin : addr_r ^ 8'hA5;
  end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Testbench: random and corner local bus cycles against a device model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        I_CLK = 1'b0, I_RESETN = 1'b0, I_REQ = 1'b0, I_REQ_WRITE = 1'b0, I_REQ_IO = 1'b0;
  logic        I_REQ_INTA = 1'b0, I_IRQ_ENABLE_FLAG = 1'b0, I_INSTR_LAST_CLK = 1'b0, I_WAIT_POLL_EXEC = 1'b0;
  logic        I_HOLD_ACK = 1'b0, I_MASKABLE_IRQ_REQUEST = 1'b0, I_POLL_N = 1'b1;
  logic [19:0] I_REQ_ADDR = 20'h00000;
  logic [7:0]  I_REQ_WDATA = 8'h00;
  logic [1:0]  I_SEGMENT = 2'h0;
  logic [3:0]  waits = 4'h0;
  wire  [7:0]  I_MUXED_ADDR_DATA_LOW, O_MUXED_ADDR_DATA_LOW, O_MID_ADDRESS_BYTE, O_RDATA;
  wire  [3:0]  O_UPPER_ADDR_STATUS;
  wire         I_READY, O_MUXED_ADDR_DATA_LOW_OE, O_MID_ADDRESS_BYTE_OE, O_UPPER_ADDR_STATUS_OE, O_ADDR_LATCH;
  wire         O_READ_N, O_WRITE_N, O_IO_SELECT, O_CTRL_OE, O_BUSY, O_DONE, O_IRQ_TAKE, O_POLL_STALL;
  int          err_total = 0;
  int          comparisons = 0;
  always #5 I_CLK = ~I_CLK;
  mlb_bus_unit dut_u (.I_CLK, .I_RESETN, .I_REQ, .I_REQ_WRITE, .I_REQ_IO, .I_REQ_INTA, .I_REQ_ADDR,
    .I_REQ_WDATA, .I_SEGMENT, .I_IRQ_ENABLE_FLAG, .I_INSTR_LAST_CLK, .I_WAIT_POLL_EXEC, .I_HOLD_ACK,
    .I_READY, .I_MASKABLE_IRQ_REQUEST, .I_POLL_N, .I_MUXED_ADDR_DATA_LOW, .O_MUXED_ADDR_DATA_LOW,
    .O_MUXED_ADDR_DATA_LOW_OE, .O_MID_ADDRESS_BYTE, .O_MID_ADDRESS_BYTE_OE, .O_UPPER_ADDR_STATUS,
    .O_UPPER_ADDR_STATUS_OE, .O_ADDR_LATCH, .O_READ_N, .O_WRITE_N, .O_IO_SELECT, .O_CTRL_OE, .O_BUSY,
    .O_DONE, .O_RDATA, .O_IRQ_TAKE, .O_POLL_STALL);
  mlb_dev_model dev_u (.i_clk(I_CLK), .i_latch(O_ADDR_LATCH), .i_read_n(O_READ_N),
    .i_addr(O_MUXED_ADDR_DATA_LOW), .i_waits(waits), .o_ready(I_READY), .o_pin(I_MUXED_ADDR_DATA_LOW));
  function automatic logic [7:0] rd_val(input logic [7:0] a);
    return a ^ 8'hA5;
  endfunction
  task automatic chk(input string nm, input logic [19:0] got, input logic [19:0] exp);
  begin
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  task automatic close_out;
  begin
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task automatic bus(input logic w, input logic io, input logic ia, input logic [19:0] a);
    int n;
    int st;
  begin
    {I_REQ_WRITE, I_REQ_IO, I_REQ_INTA, I_REQ_ADDR} = {w, io, ia, a};
    I_REQ_WDATA = 8'($urandom);
    I_SEGMENT = 2'($urandom);
    I_IRQ_ENABLE_FLAG = 1'($urandom);
    waits = 4'($urandom_range(5));
    I_REQ = 1'b1;
    for (n = 0; n < 6 && O_ADDR_LATCH !== 1'b1; n++) @(negedge I_CLK);
    if (n == 6)
    begin
      err_total++;
      close_out();
    end
    I_REQ = 1'b0;
    chk("low oe", O_MUXED_ADDR_DATA_LOW_OE, !ia);
    if (!ia) chk("low addr", O_MUXED_ADDR_DATA_LOW, a[7:0]);
    chk("upper", O_UPPER_ADDR_STATUS, io ? mlb_pkg::IO_UPPER_ADDR : a[19:16]);
    chk("space", O_IO_SELECT, io);
    st = 0;
    for (n = 0; n < 40 && O_DONE !== 1'b1; n++)
    begin
      chk("latch once", O_ADDR_LATCH, n == 0);
      if (O_BUSY === 1'b1) chk("mid", O_MID_ADDRESS_BYTE, a[15:8]);
      if (O_BUSY === 1'b1) chk("bus oe", {O_MID_ADDRESS_BYTE_OE, O_UPPER_ADDR_STATUS_OE, O_CTRL_OE}, 3'h7);
      if (ia && O_BUSY === 1'b1) chk("inta oe", O_MUXED_ADDR_DATA_LOW_OE, 1'b0);
      if ((O_READ_N & O_WRITE_N) === 1'b0)
      begin
        st++;
        chk("status", O_UPPER_ADDR_STATUS, {mlb_pkg::STATUS_MSB_VAL, I_IRQ_ENABLE_FLAG, I_SEGMENT});
        chk("strobe", O_WRITE_N, !w);
        chk("read strobe", O_READ_N, w);
        chk("data oe", O_MUXED_ADDR_DATA_LOW_OE, w);
        if (w) chk("wdata", O_MUXED_ADDR_DATA_LOW, I_REQ_WDATA);
      end
      I_IRQ_ENABLE_FLAG = 1'($urandom);
      @(negedge I_CLK);
    end
    if (n == 40)
    begin
      err_total++;
      close_out();
    end
    chk("strobe len", 20'(st), ia ? 20'h00000 : 20'(2 + waits));
    if (!w && !ia) chk("rdata", O_RDATA, rd_val(a[7:0]));
  end
  endtask
  initial
  begin
    int n;
    void'($urandom(27));
    repeat (20) @(negedge I_CLK);
    I_RESETN = 1'b1;
    bus(1'b0, 1'b0, 1'b0, 20'hFFFFF);
    bus(1'b1, 1'b1, 1'b0, 20'hFFFFF);
    bus(1'b0, 1'b0, 1'b1, 20'h00000);
    repeat (40) bus(1'($urandom), 1'($urandom), 1'b0, 20'($urandom));
    I_HOLD_ACK = 1'b1;
    I_REQ = 1'b1;
    repeat (4) @(negedge I_CLK);
    chk("hold", {O_MUXED_ADDR_DATA_LOW_OE, O_MID_ADDRESS_BYTE_OE, O_UPPER_ADDR_STATUS_OE, O_CTRL_OE, O_BUSY}, 5'h00);
    chk("latch", O_ADDR_LATCH, 1'b0);
    I_HOLD_ACK = 1'b0;
    bus(1'b0, 1'b1, 1'b0, 20'($urandom));
    I_WAIT_POLL_EXEC = 1'b1;
    repeat (6) @(negedge I_CLK);
    chk("stall", O_POLL_STALL, 1'b1);
    I_POLL_N = 1'b0;
    repeat (5) @(negedge I_CLK);
    chk("go", O_POLL_STALL, 1'b0);
    I_WAIT_POLL_EXEC = 1'b0;
    I_MASKABLE_IRQ_REQUEST = 1'b1;
    repeat (5) @(negedge I_CLK);
    chk("no take", O_IRQ_TAKE, 1'b0);
    I_INSTR_LAST_CLK = 1'b1;
    @(negedge I_CLK);
    I_INSTR_LAST_CLK = 1'b0;
    for (n = 0; n < 6 && O_IRQ_TAKE !== 1'b1; n++) @(negedge I_CLK);
    chk("take", O_IRQ_TAKE, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
